// [verilog/lwrt_pkg.sv]
// Overview of operation
// - counter advances on low-frequency oscillator edges
// - overflow forces whole-chip reset request
// - after reset: enabled, counting, longest interval
// - software may disable unless lock engaged
// - lock blocks disable/settings until system reset
// - overflow reset never drives external reset pin
package lwrt_pkg;

   // -----------------------------------------------------------------
   // counter geometry
   // -----------------------------------------------------------------
   localparam int SEL_W = 3;
   localparam int BASE_BITS = 10;
   localparam int CNT_W = 17;
   localparam logic [SEL_W-1:0] SEL_MAX = 3'h7;
   localparam logic [SEL_W-1:0] SEL_RESET = SEL_MAX;

   // -----------------------------------------------------------------
   // reset request hold, in system clock cycles
   // -----------------------------------------------------------------
   localparam int RST_HOLD_CYCLES = 16;
   localparam int HOLD_W = 5;

   typedef enum logic [1:0] {
      ST_STOPPED,
      ST_COUNTING,
      ST_RESETTING
   } lwrt_state_t;

endpackage

// [verilog/lwrt_lfo_edge.sv]
`timescale 1ns/1ps
module lwrt_lfo_edge
   import lwrt_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic lowFreqOsc,
   output logic lfoTick
);

   logic lfoPrev_r;
   logic lfoPrev_nxt;

   // -----------------------------------------------------------------
   // rising edge of the slow oscillator
   // -----------------------------------------------------------------
   // previous level; frozen when clock enable is low
   always_comb begin
      lfoPrev_nxt = clkEn ? lowFreqOsc : lfoPrev_r;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lfoPrev_r <= 1'b0;
      end else begin
         lfoPrev_r <= lfoPrev_nxt;
      end
   end

   // one system cycle per oscillator edge
   assign lfoTick = clkEn & lowFreqOsc & ~lfoPrev_r;

endmodule // lwrt_lfo_edge

// [verilog/lwrt_top.sv]
`timescale 1ns/1ps
module lwrt_top
   import lwrt_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic lowFreqOsc,
   input wire logic restartPulse,
   input wire logic disablePulse,
   input wire logic enablePulse,
   input wire logic lockPulse,
   input wire logic selWrite,
   input wire logic [SEL_W-1:0] selData,
   output logic chipResetReq,
   output logic rstPinOut,
   output logic rstPinOe,
   output logic wdRunning,
   output logic wdLocked,
   output logic [SEL_W-1:0] timeoutSel,
   output logic [CNT_W-1:0] countValue
);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   lwrt_state_t state_r;
   lwrt_state_t state_nxt;
   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] count_nxt;
   logic [SEL_W-1:0] sel_r;
   logic [SEL_W-1:0] sel_nxt;
   logic locked_r;
   logic locked_nxt;
   logic [HOLD_W-1:0] hold_r;
   logic [HOLD_W-1:0] hold_nxt;
   logic resetReq_r;
   logic resetReq_nxt;
   logic lfoTick;
   logic [CNT_W-1:0] limit;

   // terminal count table and decoded commands, one cycle wide
   logic [CNT_W-1:0] limitTab [0:(1<<SEL_W)-1];
   logic isCounting;
   logic doStart;
   logic doDisable;
   logic doRestart;
   logic doTick;
   logic overflow;
   logic holdDone;

   // -----------------------------------------------------------------
   // oscillator edge detector
   // -----------------------------------------------------------------
   lwrt_lfo_edge lwrt_lfo_edge_i (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clkEn(clkEn),
      .lowFreqOsc(lowFreqOsc),
      .lfoTick(lfoTick)
   );

   // terminal counts 2^(BASE_BITS+sel) - 1, one entry per select value
   // the longest entry fills the counter exactly
   for (genvar g = 0; g < (1 << SEL_W); g++) begin : g_limit
      assign limitTab[g] = {CNT_W{1'b1}} >> (CNT_W - BASE_BITS - g);
   end

   assign limit = limitTab[sel_r];

   // -----------------------------------------------------------------
   // command decode, shared by the state groups below
   // -----------------------------------------------------------------
   // while counting: disable beats restart, restart beats a tick
   assign isCounting = (state_r == ST_COUNTING);
   // locking also means locked on: a stopped counter resumes
   assign doStart = (state_r == ST_STOPPED) && (enablePulse || lockPulse);
   // a lock in the same cycle wins over a disable
   assign doDisable = isCounting && disablePulse && !locked_r
      && !lockPulse;
   // restart is ignored while stopped or while the request is out
   assign doRestart = isCounting && restartPulse && !doDisable;
   assign doTick = isCounting && lfoTick && !doDisable
      && !restartPulse;
   // the tick seen at terminal count is the overflow
   assign overflow = doTick && (count_r >= limit);
   // last cycle of the stretched request
   assign holdDone = (hold_r == '0);

   // -----------------------------------------------------------------
   // control state
   // -----------------------------------------------------------------
   // resetting lasts as long as the request stretcher runs
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_STOPPED: begin
            if (doStart) begin
               state_nxt = ST_COUNTING;
            end
         end
         ST_COUNTING: begin
            if (doDisable) begin
               state_nxt = ST_STOPPED;
            end else if (overflow) begin
               state_nxt = ST_RESETTING;
            end
         end
         ST_RESETTING: begin
            // the block is not reset by its own request
            if (holdDone) begin
               state_nxt = ST_COUNTING;
            end
         end
         default: begin
            // unused code: fall back to counting, never to stopped
            state_nxt = ST_COUNTING;
         end
      endcase
   end

   // comes up enabled and counting
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_COUNTING;
      end else if (clkEn) begin
         state_r <= state_nxt;
      end
   end

   // -----------------------------------------------------------------
   // chip reset request stretcher
   // -----------------------------------------------------------------
   // request held a fixed time so every domain sees it
   always_comb begin
      hold_nxt = hold_r;
      resetReq_nxt = resetReq_r;
      if (overflow) begin
         // overflow: raise the chip reset request
         resetReq_nxt = 1'b1;
         hold_nxt = HOLD_W'(RST_HOLD_CYCLES - 1);
      end else if (resetReq_r) begin
         if (holdDone) begin
            resetReq_nxt = 1'b0;
         end else begin
            hold_nxt = hold_r - 1'b1;
         end
      end
   end

   // released by reset; a restart cannot cut it short
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hold_r <= '0;
         resetReq_r <= 1'b0;
      end else if (clkEn) begin
         hold_r <= hold_nxt;
         resetReq_r <= resetReq_nxt;
      end
   end

   // -----------------------------------------------------------------
   // supervision counter
   // -----------------------------------------------------------------
   // start, stop, restart and overflow all begin again from zero
   always_comb begin
      count_nxt = count_r;
      if (doStart || doDisable || doRestart || overflow) begin
         count_nxt = '0;
      end else if (doTick) begin
         count_nxt = count_r + 1'b1;
      end
   end

   // frozen with the rest of the block while clkEn is low
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= '0;
      end else if (clkEn) begin
         count_r <= count_nxt;
      end
   end

   // -----------------------------------------------------------------
   // timeout select and lock
   // -----------------------------------------------------------------
   // lock only ever sets; it is cleared by rst_n alone
   always_comb begin
      locked_nxt = locked_r | lockPulse;
      sel_nxt = sel_r;
      // settings change only while unlocked; a write in the locking
      // cycle still lands, the lock guards from the next cycle on
      if (selWrite && !locked_r) begin
         sel_nxt = selData;
      end
   end

   // reset restores the longest interval and clears the lock
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sel_r <= SEL_RESET;
         locked_r <= 1'b0;
      end else if (clkEn) begin
         sel_r <= sel_nxt;
         locked_r <= locked_nxt;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   // request straight from its flop: no glitch into the reset tree
   assign chipResetReq = resetReq_r;
   // the external reset pin is never driven by this block,
   // so a watchdog reset leaves the pin level to the board
   assign rstPinOut = 1'b0;
   assign rstPinOe = 1'b0;
   // status; running stays high while the request is out
   assign wdRunning = (state_r != ST_STOPPED);
   assign wdLocked = locked_r;
   assign timeoutSel = sel_r;
   assign countValue = count_r;

endmodule // lwrt_top

// [verif/lwrt_top_sva.sv]
`timescale 1ns/1ps
module lwrt_top_sva
   import lwrt_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic restartPulse,
   input wire logic disablePulse,
   input wire logic lockPulse,
   input wire logic selWrite,
   input wire logic [SEL_W-1:0] selData,
   input wire logic chipResetReq,
   input wire logic rstPinOut,
   input wire logic rstPinOe,
   input wire logic wdRunning,
   input wire logic wdLocked,
   input wire logic [SEL_W-1:0] timeoutSel,
   input wire logic [CNT_W-1:0] countValue
);
   // ---------------------------------------------
   // port relations
   // ---------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // the reset pin stays released at all times
   pin_idle_a: assert property (!rstPinOe && !rstPinOut)
      else $error("pin driven");
   ovf_cause_a: assert property ($rose(chipResetReq) |->
      $past(countValue) >=
      ({CNT_W{1'b1}} >> (CNT_W - BASE_BITS - $past(timeoutSel))))
      else $error("request without full count");
   hold_len_a: assert property ($rose(chipResetReq) |->
      chipResetReq[*8] ##1 chipResetReq[*8] ##1 !chipResetReq)
      else $error("request length");
   restart_clr_a: assert property (clkEn && restartPulse && wdRunning
      && !chipResetReq && !disablePulse |=> countValue == 0)
      else $error("restart kept count");
   sel_load_a: assert property (clkEn && selWrite && !wdLocked
      |=> timeoutSel == $past(selData))
      else $error("select not loaded");
   dis_stop_a: assert property (clkEn && disablePulse && !wdLocked
      && !lockPulse && !chipResetReq |=> !wdRunning)
      else $error("disable ignored");
   lock_set_a: assert property (clkEn && lockPulse
      |=> wdLocked && wdRunning)
      else $error("lock not set");
   lock_stick_a: assert property (wdLocked |=> wdLocked)
      else $error("lock dropped");
   lock_run_a: assert property (wdLocked |=> wdRunning)
      else $error("stopped while locked");
   sel_frozen_a: assert property (wdLocked |=> $stable(timeoutSel))
      else $error("select changed while locked");
   freeze_hold_a: assert property (!clkEn |=>
      $stable(countValue) && $stable(chipResetReq))
      else $error("state moved while clock enable low");
   cover property ($rose(chipResetReq));
   cover property (wdLocked && disablePulse);
   cover property (!wdRunning);
endmodule // lwrt_top_sva

// [verif/lwrt_top_tb_top.sv]
`timescale 1ns/1ps
module lwrt_top_tb_top
   import lwrt_pkg::*;
;
   logic clk_sys = 1'b0, rst_n = 1'b0, clkEn = 1'b1, lowFreqOsc = 1'b0;
   logic restartPulse = 1'b0, disablePulse = 1'b0, enablePulse = 1'b0;
   logic lockPulse = 1'b0, selWrite = 1'b0;
   logic [SEL_W-1:0] selData = 3'h0, timeoutSel;
   logic chipResetReq, rstPinOut, rstPinOe, wdRunning, wdLocked;
   logic [CNT_W-1:0] countValue;
   int errors = 0, samples_checked = 0, cyc = 0;
   // ---------------------------------------------
   // harness
   // ---------------------------------------------
   lwrt_top lwrt_top_i (.*);
   initial forever #20 clk_sys = ~clk_sys;
   // hang guard, well above the ~2200 cycles the run needs
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         errors++;
         summarize();
      end
   end
   task automatic pulse(ref logic s);
      @(negedge clk_sys) s = 1'b1;
      @(negedge clk_sys) s = 1'b0;
   endtask
   // slow oscillator edges, then settle for the edge detector
   task automatic tick(int n);
      repeat (n) begin
         @(negedge clk_sys) lowFreqOsc = 1'b1;
         @(negedge clk_sys) lowFreqOsc = 1'b0;
      end
      repeat (3) @(negedge clk_sys);
   endtask
   task automatic cmp(logic [CNT_W-1:0] got, logic [CNT_W-1:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // main sequence; clkEn held high except while the frozen-count check drives it low
   initial begin
      repeat (8) @(negedge clk_sys);
      rst_n = 1'b1;
      @(negedge clk_sys);
      cmp(wdRunning, 1);
      cmp(timeoutSel, 7);
      tick(5);
      cmp(countValue, 5);
      // oscillator edges while frozen must not count
      clkEn = 1'b0;
      tick(2);
      cmp(countValue, 5);
      clkEn = 1'b1;
      pulse(restartPulse);
      cmp(countValue, 0);
      pulse(selWrite);
      cmp(timeoutSel, 0);
      tick(1023);
      cmp(chipResetReq, 0);
      cmp(countValue, 1023);
      tick(1);
      cmp(chipResetReq, 1);
      cmp(rstPinOe, 0);
      repeat (20) @(negedge clk_sys);
      cmp(chipResetReq, 0);
      pulse(disablePulse);
      tick(3);
      cmp(wdRunning, 0);
      cmp(countValue, 0);
      pulse(enablePulse);
      pulse(lockPulse);
      cmp(wdLocked, 1);
      pulse(disablePulse);
      selData = 3'h3;
      pulse(selWrite);
      cmp({wdRunning, timeoutSel}, 8);
      rst_n = 1'b0;
      @(negedge clk_sys) rst_n = 1'b1;
      @(negedge clk_sys);
      cmp({wdLocked, timeoutSel}, 7);
      cmp(wdRunning, 1);
      cmp(countValue, 0);
      // a lock from stopped also starts the counter
      pulse(disablePulse);
      cmp(wdRunning, 0);
      pulse(lockPulse);
      cmp(wdRunning, 1);
      cmp(wdLocked, 1);
      summarize();
   end
endmodule // lwrt_top_tb_top
bind lwrt_top lwrt_top_sva lwrt_top_sva_i (.*);
